/* File: design/owr_pkg.sv */
package owr_pkg;

    // ----------------------------------------
    // configuration byte and scratchpad reserved bytes
    // ----------------------------------------
    localparam logic [3:0] CFG_OFFSET = 4'h4;
    localparam int CFG_RES_POS = 5;
    localparam logic [7:0] CFG_RESET = 8'h7F;
    localparam logic [7:0] CFG_KEEP = 8'h60;
    localparam logic [7:0] CFG_FIXED = 8'h1F;
    localparam logic [3:0] RES_BASE = 4'h9;
    localparam logic [1:0] RES_TOP = 2'h3;
    localparam logic [7:0] SP_RSVD5 = 8'hFF;
    localparam logic [7:0] SP_RSVD6 = 8'h00;
    localparam logic [7:0] SP_RSVD7 = 8'h10;

    // ----------------------------------------
    // identifier commands, crc feedback, last-bit indices and search phase
    // ----------------------------------------
    localparam logic [7:0] CMD_READ = 8'h33;
    localparam logic [7:0] CMD_MATCH = 8'h55;
    localparam logic [7:0] CMD_SKIP = 8'hCC;
    localparam logic [7:0] CMD_SEARCH = 8'hF0;
    localparam logic [7:0] CMD_ALARM = 8'hEC;
    localparam logic [7:0] CRC_FEEDBACK = 8'h8C;
    localparam logic [5:0] LAST_ID_BIT = 6'h3F;
    localparam logic [5:0] LAST_CMD_BIT = 6'h07;
    localparam logic [1:0] PH_ECHO = 2'h2;

    // ----------------------------------------
    // timing, counter width and sequencer states
    // ----------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int RESET_LOW_US = 480;
    localparam int PRES_WAIT_US = 30;
    localparam int PRES_LOW_US = 120;
    localparam int SAMPLE_US = 30;
    localparam int CONV_TIME_MAX_US = 750000;
    localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
    localparam int PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
    localparam int PRES_LOW_CYC = PRES_LOW_US * CLK_MHZ;
    localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
    localparam int CONV_MAX_CYC = CONV_TIME_MAX_US * CLK_MHZ;
    localparam int CNT_W = 17;

    typedef enum logic [8:0] {
        ST_WAIT_RST = 9'h001,
        ST_RST_LOW = 9'h002,
        ST_PRES_WAIT = 9'h004,
        ST_PRES_DRIVE = 9'h008,
        ST_ROM_CMD = 9'h010,
        ST_ROM_TX = 9'h020,
        ST_MATCH = 9'h040,
        ST_SEARCH = 9'h080,
        ST_FUNC = 9'h100
    } owr_state_t;

endpackage

/* File: design/owr_stream_if.sv */
`timescale 1ns/1ps
interface owr_stream_if #(
    parameter int W = 8
);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface

/* File: design/owr_crc8.sv */
`timescale 1ns/1ps
module owr_crc8 #(
    parameter int W = 56
) (
    // message, bit 0 shifted in first
    input wire logic [W-1:0] data,
    // remainder
    output logic [7:0] crc
);
    always_comb begin
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < W; i++) begin
            if (c[0] ^ data[i]) begin
                c = (c >> 1) ^ owr_pkg::CRC_FEEDBACK;
            end else begin
                c = c >> 1;
            end
        end
        crc = c;
    end
endmodule

/* File: design/owr_fifo.sv */
`timescale 1ns/1ps
module owr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    owr_stream_if.snk wr,
    // drain side
    output logic [W-1:0] rdData,
    output logic rdValid,
    input wire logic rdReady
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWr;
    logic doRd;

    assign wr.ready = count_reg != (AW + 1)'(DEPTH);
    assign rdValid = count_reg != '0;
    assign rdData = mem[rdPtr_reg];
    assign doWr = wr.valid && wr.ready;
    assign doRd = rdValid && rdReady;

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW + 1)'(doWr) - (AW + 1)'(doRd);
        end
    end
endmodule

/* File: design/owr_rom_layer.sv */
`timescale 1ns/1ps
module owr_rom_layer #(
    // family byte and serial; value is arbitrary
    parameter logic [55:0] ROM_BODY = 56'h0123456789AB5A,
    parameter int RESET_CYC = owr_pkg::RESET_LOW_CYC,
    parameter int PRES_LOW_CYC = owr_pkg::PRES_LOW_CYC,
    parameter int SAMPLE_CYC = owr_pkg::SAMPLE_CYC,
    parameter logic [31:0] CONV_MAX_CYC = 32'(owr_pkg::CONV_MAX_CYC),
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // single-wire pin
    input wire logic dqIn,
    output logic dqOut,
    output logic dqOe,
    // scratchpad sources and alarm flag
    input wire logic cfgWrEn,
    input wire logic [7:0] cfgWrData,
    input wire logic [7:0] thByte,
    input wire logic [7:0] tlByte,
    input wire logic [15:0] tempWord,
    input wire logic alarmFlag,
    // status
    output logic addressed,
    output logic [7:0] configByte,
    output logic [3:0] resolutionBits,
    output logic [31:0] convTimeCycles,
    output logic [7:0] scratchCrc,
    // function byte stream
    output logic [7:0] funcData,
    output logic funcValid,
    input wire logic funcReady
);
    localparam int CW = owr_pkg::CNT_W;

    owr_pkg::owr_state_t state_reg;
    owr_pkg::owr_state_t stateNext;
    logic dqMeta_reg;
    logic dqSync_reg;
    logic dqPrev_reg;
    logic dqOe_reg;
    logic [CW-1:0] lowCnt_reg;
    logic [CW-1:0] slotCnt_reg;
    logic slotOn_reg;
    logic [5:0] bitIdx_reg;
    logic [1:0] phase_reg;
    logic [7:0] cmd_reg;
    logic [7:0] rxByte_reg;
    logic miss_reg;
    logic pushValid_reg;
    logic addressed_reg;
    logic [7:0] cfg_reg;
    logic [3:0] resBits_reg;
    logic [31:0] convCyc_reg;
    logic [7:0] spCrc_reg;
    logic [7:0] romCrc;
    logic [7:0] spCrcNow;
    logic [63:0] romId;
    logic [7:0] newCmd;
    logic fall;
    logic rise;
    logic rstHit;
    logic engaged;
    logic slotStart;
    logic bitDone;
    logic rxBit;
    logic romBit;
    logic txZero;
    logic stateChg;

    owr_stream_if #(.W(8)) pushIf ();

    // ----------------------------------------
    // CRC generators
    // ----------------------------------------
    owr_crc8 #(.W(56)) uRomCrc (
        .data(ROM_BODY),
        .crc(romCrc)
    );

    owr_crc8 #(.W(64)) uSpCrc (
        .data({owr_pkg::SP_RSVD7, owr_pkg::SP_RSVD6, owr_pkg::SP_RSVD5,
               cfg_reg, tlByte, thByte, tempWord}),
        .crc(spCrcNow)
    );

    assign romId = {romCrc, ROM_BODY};

    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dqMeta_reg <= 1'b1;
            dqSync_reg <= 1'b1;
            dqPrev_reg <= 1'b1;
        end else begin
            dqMeta_reg <= dqIn;
            dqSync_reg <= dqMeta_reg;
            dqPrev_reg <= dqSync_reg;
        end
    end

    assign fall = dqPrev_reg && !dqSync_reg;
    assign rise = !dqPrev_reg && dqSync_reg;

    // low-width meter; saturates so a stuck-low line stays in reset
    always_ff @(posedge clk) begin
        if (sys_rst || dqSync_reg) begin
            lowCnt_reg <= '0;
        end else if (lowCnt_reg != CW'(RESET_CYC)) begin
            lowCnt_reg <= lowCnt_reg + 1'b1;
        end
    end

    assign rstHit = (lowCnt_reg == CW'(RESET_CYC)) && !dqSync_reg;

    // ----------------------------------------
    // slot decode
    // ----------------------------------------
    assign engaged = state_reg inside {owr_pkg::ST_ROM_CMD,
        owr_pkg::ST_ROM_TX, owr_pkg::ST_MATCH, owr_pkg::ST_SEARCH,
        owr_pkg::ST_FUNC};
    // a full push stage makes the slave ignore the next slot so the held byte is not overwritten
    assign slotStart = fall && engaged && !slotOn_reg && !dqOe_reg &&
        !(state_reg == owr_pkg::ST_FUNC && pushValid_reg);
    assign bitDone = slotOn_reg &&
        slotCnt_reg == CW'(SAMPLE_CYC - 1);
    assign rxBit = dqSync_reg;
    assign romBit = romId[bitIdx_reg];
    assign newCmd = {rxBit, cmd_reg[7:1]};
    assign stateChg = stateNext != state_reg;

    always_comb begin
        txZero = 1'b0;
        if (state_reg == owr_pkg::ST_ROM_TX) begin
            txZero = !romBit;
        end else if (state_reg == owr_pkg::ST_SEARCH) begin
            if (phase_reg == 2'h0) begin
                txZero = !romBit;
            end else if (phase_reg == 2'h1) begin
                txZero = romBit;
            end
        end
    end

    // ----------------------------------------
    // transaction sequencer
    // ----------------------------------------
    always_comb begin
        stateNext = state_reg;
        if (rstHit) begin
            stateNext = owr_pkg::ST_RST_LOW;
        end else begin
            unique case (state_reg)
                owr_pkg::ST_WAIT_RST: begin
                    stateNext = owr_pkg::ST_WAIT_RST;
                end
                owr_pkg::ST_RST_LOW: begin
                    if (rise) begin
                        stateNext = owr_pkg::ST_PRES_WAIT;
                    end
                end
                owr_pkg::ST_PRES_WAIT: begin
                    if (slotCnt_reg == CW'(owr_pkg::PRES_WAIT_CYC - 1)) begin
                        stateNext = owr_pkg::ST_PRES_DRIVE;
                    end
                end
                owr_pkg::ST_PRES_DRIVE: begin
                    if (slotCnt_reg == CW'(PRES_LOW_CYC - 1)) begin
                        stateNext = owr_pkg::ST_ROM_CMD;
                    end
                end
                owr_pkg::ST_ROM_CMD: begin
                    if (bitDone && bitIdx_reg == owr_pkg::LAST_CMD_BIT) begin
                        unique case (newCmd)
                            owr_pkg::CMD_READ: begin
                                stateNext = owr_pkg::ST_ROM_TX;
                            end
                            owr_pkg::CMD_MATCH: begin
                                stateNext = owr_pkg::ST_MATCH;
                            end
                            owr_pkg::CMD_SKIP: begin
                                stateNext = owr_pkg::ST_FUNC;
                            end
                            owr_pkg::CMD_SEARCH: begin
                                stateNext = owr_pkg::ST_SEARCH;
                            end
                            owr_pkg::CMD_ALARM: begin
                                stateNext = alarmFlag ? owr_pkg::ST_SEARCH
                                    : owr_pkg::ST_WAIT_RST;
                            end
                            default: begin
                                stateNext = owr_pkg::ST_WAIT_RST;
                            end
                        endcase
                    end
                end
                owr_pkg::ST_ROM_TX: begin
                    if (bitDone && bitIdx_reg == owr_pkg::LAST_ID_BIT) begin
                        stateNext = owr_pkg::ST_FUNC;
                    end
                end
                owr_pkg::ST_MATCH: begin
                    if (bitDone && bitIdx_reg == owr_pkg::LAST_ID_BIT) begin
                        stateNext = (miss_reg || rxBit != romBit)
                            ? owr_pkg::ST_WAIT_RST
                            : owr_pkg::ST_FUNC;
                    end
                end
                owr_pkg::ST_SEARCH: begin
                    if (bitDone && phase_reg == owr_pkg::PH_ECHO) begin
                        if (rxBit != romBit ||
                            bitIdx_reg == owr_pkg::LAST_ID_BIT) begin
                            stateNext = owr_pkg::ST_WAIT_RST;
                        end
                    end
                end
                owr_pkg::ST_FUNC: begin
                    stateNext = owr_pkg::ST_FUNC;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= owr_pkg::ST_WAIT_RST;
        end else begin
            state_reg <= stateNext;
        end
    end

    // one timer serves presence phases and bit slots
    always_ff @(posedge clk) begin
        if (sys_rst || stateChg) begin
            slotCnt_reg <= '0;
            slotOn_reg <= 1'b0;
        end else if (state_reg inside {owr_pkg::ST_PRES_WAIT,
                     owr_pkg::ST_PRES_DRIVE}) begin
            slotCnt_reg <= slotCnt_reg + 1'b1;
        end else if (slotStart) begin
            slotCnt_reg <= '0;
            slotOn_reg <= 1'b1;
        end else if (bitDone) begin
            slotOn_reg <= 1'b0;
        end else if (slotOn_reg) begin
            slotCnt_reg <= slotCnt_reg + 1'b1;
        end
    end

    // ----------------------------------------
    // bit datapath
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || stateChg) begin
            bitIdx_reg <= '0;
            phase_reg <= '0;
            miss_reg <= 1'b0;
        end else if (bitDone) begin
            unique case (state_reg)
                owr_pkg::ST_MATCH: begin
                    miss_reg <= miss_reg || rxBit != romBit;
                    bitIdx_reg <= bitIdx_reg + 1'b1;
                end
                owr_pkg::ST_SEARCH: begin
                    if (phase_reg == owr_pkg::PH_ECHO) begin
                        phase_reg <= '0;
                        bitIdx_reg <= bitIdx_reg + 1'b1;
                    end else begin
                        phase_reg <= phase_reg + 1'b1;
                    end
                end
                default: begin
                    bitIdx_reg <= bitIdx_reg + 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_reg <= '0;
            rxByte_reg <= '0;
        end else if (bitDone) begin
            if (state_reg == owr_pkg::ST_ROM_CMD) begin
                cmd_reg <= newCmd;
            end
            if (state_reg == owr_pkg::ST_FUNC) begin
                rxByte_reg <= {rxBit, rxByte_reg[7:1]};
            end
        end
    end

    // push stage into the buffer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pushValid_reg <= 1'b0;
        end else if (bitDone && state_reg == owr_pkg::ST_FUNC &&
                     bitIdx_reg[2:0] == 3'h7) begin
            pushValid_reg <= 1'b1;
        end else if (pushIf.ready) begin
            pushValid_reg <= 1'b0;
        end
    end

    assign pushIf.valid = pushValid_reg;
    assign pushIf.data = rxByte_reg;

    owr_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) uFifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(pushIf),
        .rdData(funcData),
        .rdValid(funcValid),
        .rdReady(funcReady)
    );

    // ----------------------------------------
    // line driver
    // ----------------------------------------
    // crc mismatches are never looked at here; the master decides
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dqOe_reg <= 1'b0;
        end else if (stateChg) begin
            dqOe_reg <= stateNext == owr_pkg::ST_PRES_DRIVE;
        end else if (slotStart) begin
            dqOe_reg <= txZero;
        end else if (bitDone) begin
            dqOe_reg <= 1'b0;
        end
    end

    assign dqOe = dqOe_reg;
    assign dqOut = 1'b0;

    // ----------------------------------------
    // configuration and status
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_reg <= owr_pkg::CFG_RESET;
        end else if (cfgWrEn) begin
            cfg_reg <= (cfgWrData & owr_pkg::CFG_KEEP) |
                owr_pkg::CFG_FIXED;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resBits_reg <= '0;
            convCyc_reg <= '0;
            spCrc_reg <= '0;
            addressed_reg <= 1'b0;
        end else begin
            resBits_reg <= owr_pkg::RES_BASE +
                4'(cfg_reg[owr_pkg::CFG_RES_POS +: 2]);
            convCyc_reg <= CONV_MAX_CYC >> (owr_pkg::RES_TOP -
                cfg_reg[owr_pkg::CFG_RES_POS +: 2]);
            spCrc_reg <= spCrcNow;
            addressed_reg <= state_reg == owr_pkg::ST_FUNC;
        end
    end

    assign configByte = cfg_reg;
    assign resolutionBits = resBits_reg;
    assign convTimeCycles = convCyc_reg;
    assign scratchCrc = spCrc_reg;
    assign addressed = addressed_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence seqPresStart;
        state_reg == owr_pkg::ST_PRES_WAIT
            ##1 state_reg == owr_pkg::ST_PRES_DRIVE;
    endsequence

    AST_PRES_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
        seqPresStart |-> dqOe_reg [*8])
        else $error("presence pulse not driven");
    AST_CFG_FIXED: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_reg & ~owr_pkg::CFG_KEEP) == owr_pkg::CFG_FIXED)
        else $error("reserved config bits changed");
    AST_CFG_RESET: assert property (@(posedge clk)
        sys_rst |=> cfg_reg == owr_pkg::CFG_RESET)
        else $error("config not 12-bit after reset");
    AST_RES_MAP: assert property (@(posedge clk) disable iff (sys_rst)
        $stable(cfg_reg) && cfg_reg[6:5] == 2'h0 |=> resBits_reg == 4'h9)
        else $error("9-bit resolution not selected");
    AST_CONV_MAX: assert property (@(posedge clk) disable iff (sys_rst)
        resBits_reg == 4'hC && $stable(cfg_reg) |-> convCyc_reg == CONV_MAX_CYC)
        else $error("12-bit conversion time wrong");
    AST_SP_CRC: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(spCrcNow) |=> spCrc_reg == $past(spCrcNow))
        else $error("scratchpad crc not updated");
    AST_RST_ABORT: assert property (@(posedge clk) disable iff (sys_rst)
        rstHit |=> state_reg == owr_pkg::ST_RST_LOW && !dqOe_reg)
        else $error("long low did not reset");
    AST_SEARCH_DROP: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == owr_pkg::ST_SEARCH && bitDone && !rstHit &&
        phase_reg == owr_pkg::PH_ECHO && rxBit != romBit
        |=> state_reg == owr_pkg::ST_WAIT_RST [*2])
        else $error("search mismatch kept device in");
    AST_SKIP_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == owr_pkg::ST_ROM_CMD && bitDone && !rstHit &&
        bitIdx_reg == 6'h07 && newCmd == owr_pkg::CMD_SKIP
        |=> ##1 addressed_reg)
        else $error("skip did not address device");
    AST_MATCH_FAIL: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == owr_pkg::ST_MATCH && miss_reg && stateChg && !rstHit
        |=> state_reg == owr_pkg::ST_WAIT_RST)
        else $error("mismatched identifier proceeded");
endmodule

/* File: sim/owr_master_model.sv */
`timescale 1ns/1ps
// bus master: only ever pulls low, the pullup does the rest
module owr_master_model (
    // clock
    input wire logic clk,
    // wire level and pull-down
    input wire logic dq,
    output logic mLow
);
    initial mLow = 1'b0;
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // long low, then time the presence answer
    task automatic busReset(output int w, output int l);
        w = 0;
        l = 0;
        hold(1);
        mLow <= 1'b1;
        hold(400);
        mLow <= 1'b0;
        // let the release reach the wire before timing the gap
        hold(1);
        while (dq && w < 9000) begin
            hold(1);
            w++;
        end
        while (!dq && l < 9000) begin
            hold(1);
            l++;
        end
        hold(50);
    endtask
    // zero stays low past the slave's sample but well under a reset
    task automatic wrBit(input logic b);
        mLow <= 1'b1;
        hold(b ? 6 : 140);
        mLow <= 1'b0;
        hold(b ? 144 : 10);
    endtask
    task automatic wrByte(input logic [7:0] v);
        hold(1);
        for (int i = 0; i < 8; i++) wrBit(v[i]);
    endtask
    // sample well inside the slave's hold
    task automatic rdBit(output logic b);
        mLow <= 1'b1;
        hold(6);
        mLow <= 1'b0;
        hold(30);
        b = dq;
        hold(114);
    endtask
endmodule

/* File: sim/onewire_sensor_rom_layer_tb_top.sv */
`timescale 1ns/1ps
module onewire_sensor_rom_layer_tb_top;
    // short conversion count so every shift shows
    localparam logic [31:0] CONV = 32'h0000_0800;
    localparam logic [55:0] BODY = 56'hA1B2C3D4E5F63C;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic cfgWrEn = 1'b0;
    logic funcReady = 1'b0;
    logic alarmFlag = 1'b0;
    logic [7:0] cfgWrData = 8'h00;
    logic [7:0] thByte = 8'h00;
    logic [7:0] tlByte = 8'h00;
    logic [15:0] tempWord = 16'h0000;
    logic [31:0] lfsr = 32'h5EE2;
    int num_errors = 0;
    int n_checks = 0;
    wire logic dqOut, dqOe, mLow, addressed, funcValid;
    wire logic [7:0] configByte, scratchCrc, funcData;
    wire logic [3:0] resolutionBits;
    wire logic [31:0] convTimeCycles;
    wire logic dq = !(mLow || (dqOe && !dqOut));
    always #4 clk = ~clk;
    // short slots keep the run small; a write-0 stays under reset length
    owr_rom_layer #(.ROM_BODY(BODY), .RESET_CYC(300), .PRES_LOW_CYC(100),
        .SAMPLE_CYC(120), .CONV_MAX_CYC(CONV)) u_owr_rom_layer (
        .clk(clk), .sys_rst(sysRst), .dqIn(dq), .dqOut(dqOut),
        .dqOe(dqOe), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData),
        .thByte(thByte), .tlByte(tlByte), .tempWord(tempWord),
        .alarmFlag(alarmFlag), .addressed(addressed),
        .configByte(configByte), .resolutionBits(resolutionBits),
        .convTimeCycles(convTimeCycles), .scratchCrc(scratchCrc),
        .funcData(funcData), .funcValid(funcValid),
        .funcReady(funcReady));
    owr_master_model u_owr_master_model (
        .clk(clk), .dq(dq), .mLow(mLow));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            fb = c[0] ^ d[i];
            c = (c >> 1) ^ (fb ? 8'h8C : 8'h00);
        end
        return c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // about 1.4 times the planned run
    initial begin
        #780_000;
        num_errors++;
        results();
    end
    initial begin
        logic [7:0] b, cfg;
        logic [63:0] rx, id, bad;
        logic [5:0] k;
        logic [1:0] r;
        logic a, ac, x;
        int w, l;
        repeat (5) @(posedge clk);
        sysRst <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(configByte, 8'h7F);
        chk(resolutionBits, 4'hC);
        chk(convTimeCycles, CONV);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            r = i[1:0];
            cfg = 8'(rnd());
            cfg[6:5] = r;
            @(posedge clk);
            cfgWrData <= cfg;
            cfgWrEn <= 1'b1;
            thByte <= 8'(rnd());
            tlByte <= 8'(rnd());
            tempWord <= 16'(rnd());
            @(posedge clk);
            cfgWrEn <= 1'b0;
            repeat (4) @(posedge clk);
            #1 chk(configByte, {1'b0, r, 5'h1F});
            chk(resolutionBits, 4'h9 + r);
            chk(convTimeCycles, CONV >> (3 - r));
            chk(scratchCrc, crc8({24'h1000FF, 1'b0, r, 5'h1F,
                tlByte, thByte, tempWord}, 64));
        end
        $display("test config done");
        u_owr_master_model.busReset(w, l);
        chk(w >= 1875 && w <= 7500, 1'b1);
        chk(l >= 96 && l <= 104, 1'b1);
        chk(addressed, 1'b0);
        u_owr_master_model.wrByte(8'hCC);
        #1 chk(addressed, 1'b1);
        b = 8'(rnd());
        u_owr_master_model.wrByte(b);
        #1 chk(funcValid, 1'b1);
        chk(funcData, b);
        @(posedge clk) funcReady <= 1'b1;
        @(posedge clk) funcReady <= 1'b0;
        #1 chk(funcValid, 1'b0);
        $display("test skip done");
        u_owr_master_model.busReset(w, l);
        chk(addressed, 1'b0);
        u_owr_master_model.wrByte(8'h33);
        for (int i = 0; i < 64; i++) u_owr_master_model.rdBit(rx[i]);
        chk(rx[31:0], BODY[31:0]);
        chk(rx[55:32], BODY[55:32]);
        chk(rx[63:56], crc8({8'h00, BODY}, 56));
        chk(crc8(rx, 64), 8'h00);
        chk(addressed, 1'b1);
        u_owr_master_model.busReset(w, l);
        chk(addressed, 1'b0);
        $display("test read done");
        id = {crc8({8'h00, BODY}, 56), BODY};
        k = 6'(rnd()) & 6'h1F;
        bad = id ^ (64'h1 << k);
        u_owr_master_model.wrByte(8'h55);
        for (int i = 0; i < 64; i++) u_owr_master_model.wrBit(bad[i]);
        chk(addressed, 1'b0);
        u_owr_master_model.busReset(w, l);
        u_owr_master_model.wrByte(8'h55);
        for (int i = 0; i < 64; i++) u_owr_master_model.wrBit(id[i]);
        chk(addressed, 1'b1);
        u_owr_master_model.busReset(w, l);
        chk(addressed, 1'b0);
        $display("test match done");
        u_owr_master_model.wrByte(8'hEC);
        u_owr_master_model.rdBit(x);
        chk(x, 1'b1);
        u_owr_master_model.busReset(w, l);
        alarmFlag <= 1'b1;
        u_owr_master_model.wrByte(8'hEC);
        u_owr_master_model.rdBit(a);
        u_owr_master_model.rdBit(ac);
        chk(a, BODY[0]);
        chk(ac, !BODY[0]);
        u_owr_master_model.wrBit(!a);
        u_owr_master_model.rdBit(x);
        chk(x, 1'b1);
        $display("test alarm done");
        u_owr_master_model.busReset(w, l);
        u_owr_master_model.wrByte(8'hF0);
        u_owr_master_model.rdBit(a);
        chk(a, BODY[0]);
        $display("test search done");
        results();
    end
endmodule
